//--- design/lbt_leak_if.sv
// primary strobe / leak pulse link between the timer and its divider
// assumes both ends run on the same memory clock
`timescale 1ns/1ns
`default_nettype none
interface lbt_leak_if;
  logic primary_strobe;
  logic [1:0] secondary_strobe_limit;
  logic leak_pulse;
  modport timer (output primary_strobe, output secondary_strobe_limit, input leak_pulse);
  modport divider (input primary_strobe, input secondary_strobe_limit, output leak_pulse);
endinterface : lbt_leak_if
`default_nettype wire

//--- design/lbt_leak_timer.sv
// leaky-bucket leak timer: 53-bit timer, two-hot threshold, leak pulses
// assumes config-space accesses are one-cycle strobes on the memory clock
// Behaviour
// - one 53-bit timer, low 11 bits hidden
// - upper 42 bits advance on hidden carry
// - low word shows timer bits 11..42
// - high word shows timer bits 43..52
// - upper select picks bit code plus 11
// - lower select uses same code mapping
// - both selected bits set: reset, strobe
// - primary strobe lasts one clock
// - 2-bit limit divides strobes into pulses
// - all-zero config disables leaking
// - registers reset zero, timer words writable
`timescale 1ns/1ns
`default_nettype none
module lbt_leak_timer (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_cfg_write,
  input wire logic i_cfg_read,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [1:0] i_secondary_strobe_limit,
  input wire logic i_ce_counter_zero,
  output logic [31:0] o_cfg_rdata,
  output logic o_primary_strobe,
  output logic o_ce_decrement
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [lbt_pkg::CFG_WIDTH-1:0] leak_threshold_config;
  logic [lbt_pkg::HIDDEN_WIDTH-1:0] hidden_count;
  logic [lbt_pkg::VISIBLE_WIDTH-1:0] visible_count;
  logic [lbt_pkg::FULL_WIDTH-1:0] full_count;
  logic [5:0] upper_threshold_select;
  logic [5:0] lower_threshold_select;
  logic threshold_match;
  logic hidden_carry;
  logic wr_cfg;
  logic wr_low;
  logic wr_high;

  lbt_leak_if leak ();

  // ---------------------------------------------------------------
  // select decode
  // ---------------------------------------------------------------
  function automatic logic select_valid(input logic [5:0] code);
    select_valid = (code >= lbt_pkg::SEL_CODE_MIN) && (code <= lbt_pkg::SEL_CODE_MAX);
  endfunction : select_valid

  function automatic logic select_bit(input logic [52:0] count, input logic [5:0] code);
    logic [5:0] pos;
    pos = 6'(code + lbt_pkg::SEL_BIT_OFFSET);
    select_bit = select_valid(code) && count[pos];
  endfunction : select_bit

  assign full_count = {visible_count, hidden_count};
  assign upper_threshold_select = leak_threshold_config[lbt_pkg::UPPER_SEL_LSB +: lbt_pkg::SEL_WIDTH];
  assign lower_threshold_select = leak_threshold_config[lbt_pkg::LOWER_SEL_LSB +: lbt_pkg::SEL_WIDTH];
  assign wr_cfg = i_cfg_write && (i_cfg_addr == lbt_pkg::OFS_THRESHOLD_CONFIG);
  assign wr_low = i_cfg_write && (i_cfg_addr == lbt_pkg::OFS_TIMER_LOW_WORD);
  assign wr_high = i_cfg_write && (i_cfg_addr == lbt_pkg::OFS_TIMER_HIGH_WORD);
  assign hidden_carry = (hidden_count == lbt_pkg::HIDDEN_MAX);

  assign threshold_match = select_bit(full_count, upper_threshold_select)
                        && select_bit(full_count, lower_threshold_select);

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // config resets to zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      leak_threshold_config <= lbt_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      leak_threshold_config <= i_cfg_wdata[lbt_pkg::CFG_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // hidden low counter
  // ---------------------------------------------------------------
  // advance every clock unless a match clears it
  always_ff @(posedge i_clock) begin
    if (i_reset || threshold_match) begin
      hidden_count <= 11'h000;
    end else begin
      hidden_count <= 11'(hidden_count + 11'h001);
    end
  end

  // ---------------------------------------------------------------
  // visible upper counter
  // ---------------------------------------------------------------
  // match reset wins over a write in the same cycle
  // count on hidden carry
  always_ff @(posedge i_clock) begin
    if (i_reset || threshold_match) begin
      visible_count <= lbt_pkg::TIMER_RESET;
    end else if (wr_low) begin
      visible_count[31:0] <= i_cfg_wdata;
    end else if (wr_high) begin
      visible_count[41:32] <= i_cfg_wdata[lbt_pkg::HIGH_WORD_WIDTH-1:0];
    end else if (hidden_carry) begin
      visible_count <= 42'(visible_count + 42'h1);
    end
  end

  // ---------------------------------------------------------------
  // primary strobe and divider
  // ---------------------------------------------------------------
  // strobe on match
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_primary_strobe <= 1'b0;
    end else begin
      o_primary_strobe <= threshold_match;
    end
  end

  assign leak.primary_strobe = o_primary_strobe;
  assign leak.secondary_strobe_limit = i_secondary_strobe_limit;

  lbt_secondary_divider u_divider (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .leak(leak.divider)
  );

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_ce_decrement <= 1'b0;
    end else begin
      o_ce_decrement <= leak.leak_pulse && !i_ce_counter_zero;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  // config, low word and high word views
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_cfg_rdata <= 32'h0000_0000;
    end else if (i_cfg_read) begin
      if (i_cfg_addr == lbt_pkg::OFS_THRESHOLD_CONFIG) begin
        o_cfg_rdata <= {20'h0_0000, leak_threshold_config};
      end else if (i_cfg_addr == lbt_pkg::OFS_TIMER_LOW_WORD) begin
        o_cfg_rdata <= visible_count[31:0];
      end else if (i_cfg_addr == lbt_pkg::OFS_TIMER_HIGH_WORD) begin
        o_cfg_rdata <= {22'h00_0000, visible_count[41:32]};
      end else begin
        o_cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_match;
    threshold_match;
  endsequence

  sequence s_cleared;
    full_count == 53'h0 && o_primary_strobe;
  endsequence

  tick_advance_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && !threshold_match |=> hidden_count == 11'($past(hidden_count) + 11'h001))
    else $error("hidden counter did not advance");

  carry_gate_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !threshold_match && !wr_low && !wr_high
      |=> visible_count == 42'($past(visible_count) + {41'h0, $past(hidden_carry)}))
    else $error("visible counter moved without carry");

  low_view_a: assert property (@(posedge i_clock) disable iff (i_reset)
    i_cfg_read && i_cfg_addr == lbt_pkg::OFS_TIMER_LOW_WORD |=> o_cfg_rdata == $past(full_count[42:11]))
    else $error("low word read wrong bits");

  high_view_a: assert property (@(posedge i_clock) disable iff (i_reset)
    i_cfg_read && i_cfg_addr == lbt_pkg::OFS_TIMER_HIGH_WORD
      |=> o_cfg_rdata == {22'h00_0000, $past(full_count[52:43])})
    else $error("high word read wrong bits");

  strobe_cause_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_primary_strobe |-> $past(full_count[6'(upper_threshold_select + lbt_pkg::SEL_BIT_OFFSET)])
      && $past(select_valid(upper_threshold_select)))
    else $error("strobe without upper selected bit");

  lower_cause_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_primary_strobe |-> $past(full_count[6'(lower_threshold_select + lbt_pkg::SEL_BIT_OFFSET)])
      && $past(select_valid(lower_threshold_select)))
    else $error("strobe without lower selected bit");

  match_reset_a: assert property (@(posedge i_clock) disable iff (i_reset)
    s_match |=> s_cleared)
    else $error("match did not clear timer and strobe");

  strobe_width_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_primary_strobe |=> !o_primary_strobe)
    else $error("primary strobe longer than one cycle");

  disabled_quiet_a: assert property (@(posedge i_clock) disable iff (i_reset)
    (leak_threshold_config == 12'h000)[*4] |-> !o_primary_strobe && !o_ce_decrement)
    else $error("leak activity with zero config");

  reset_zero_a: assert property (@(posedge i_clock)
    $past(i_reset) |-> leak_threshold_config == 12'h000 && visible_count == 42'h0)
    else $error("register not zero after reset");

  floor_guard_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_ce_decrement |-> $past(leak.leak_pulse) && !$past(i_ce_counter_zero))
    else $error("decrement at zero or without pulse");

  // ---------------------------------------------------------------
  // register port checks
  // ---------------------------------------------------------------
  // sampled reset in an antecedent keeps the release edge out,
  // where the disable condition already sees reset low
  config_write_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && wr_cfg |=> leak_threshold_config == $past(i_cfg_wdata[lbt_pkg::CFG_WIDTH-1:0]))
    else $error("config write not taken");

  low_write_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && wr_low && !threshold_match |=> visible_count[31:0] == $past(i_cfg_wdata))
    else $error("low word write not taken");

  high_write_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && wr_high && !threshold_match |=> visible_count[41:32] == $past(i_cfg_wdata[9:0]))
    else $error("high word write not taken");

  config_view_a: assert property (@(posedge i_clock) disable iff (i_reset)
    i_cfg_read && i_cfg_addr == lbt_pkg::OFS_THRESHOLD_CONFIG
      |=> o_cfg_rdata == {20'h0_0000, $past(leak_threshold_config)})
    else $error("config read wrong value");

  rdata_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && !i_cfg_read |=> $stable(o_cfg_rdata))
    else $error("read data changed without a read");

  reset_outputs_a: assert property (@(posedge i_clock)
    $past(i_reset) |-> !o_primary_strobe && !o_ce_decrement && o_cfg_rdata == 32'h0000_0000)
    else $error("output not zero after reset");

  // ---------------------------------------------------------------
  // timer and leak path checks
  // ---------------------------------------------------------------
  sequence s_pulse_allowed;
    leak.leak_pulse && !i_ce_counter_zero;
  endsequence

  sequence s_decrement;
    o_ce_decrement;
  endsequence

  hidden_wrap_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && hidden_carry |=> hidden_count == 11'h000)
    else $error("hidden counter did not wrap");

  carry_step_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && hidden_carry && !threshold_match && !wr_low && !wr_high
      |=> visible_count == 42'($past(visible_count) + 42'h1))
    else $error("carry did not step the visible counter");

  strobe_gap_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_primary_strobe |-> !threshold_match)
    else $error("match right after a strobe");

  timer_restart_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_primary_strobe && !wr_low && !wr_high |=> full_count == 53'h1)
    else $error("timer did not restart from zero");

  decrement_follow_a: assert property (@(posedge i_clock) disable iff (i_reset)
    s_pulse_allowed |=> s_decrement)
    else $error("leak pulse did not decrement");

  decrement_width_a: assert property (@(posedge i_clock) disable iff (i_reset)
    o_ce_decrement |=> !o_ce_decrement)
    else $error("decrement longer than one cycle");

  zero_floor_a: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_reset && i_ce_counter_zero |=> !o_ce_decrement)
    else $error("decrement while counter at zero");

endmodule : lbt_leak_timer
`default_nettype wire

//--- design/lbt_pkg.sv
// constants used by the leak timer, not by its secondary divider
// assumes a single memory clock domain and a synchronous active-high reset
package lbt_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_THRESHOLD_CONFIG = 8'hB8;
  localparam logic [7:0] OFS_TIMER_LOW_WORD = 8'hC0;
  localparam logic [7:0] OFS_TIMER_HIGH_WORD = 8'hC4;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int UPPER_SEL_LSB = 6;
  localparam int LOWER_SEL_LSB = 0;
  localparam int SEL_WIDTH = 6;
  localparam int CFG_WIDTH = 12;
  localparam int HIGH_WORD_WIDTH = 10;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [41:0] TIMER_RESET = 42'h000_0000_0000;

  // ---------------------------------------------------------------
  // counter geometry and select code range
  // ---------------------------------------------------------------
  localparam int FULL_WIDTH = 53;
  localparam int HIDDEN_WIDTH = 11;
  localparam int VISIBLE_WIDTH = 42;
  localparam logic [10:0] HIDDEN_MAX = 11'h7FF;
  localparam logic [5:0] SEL_BIT_OFFSET = 6'h0B;
  localparam logic [5:0] SEL_CODE_MIN = 6'h01;
  localparam logic [5:0] SEL_CODE_MAX = 6'h29;

endpackage : lbt_pkg

//--- design/lbt_secondary_divider.sv
// divides primary leak strobes into leak pulses by a 2-bit ratio
// assumes strobes are one cycle wide and come from the same clock
`timescale 1ns/1ns
`default_nettype none
module lbt_secondary_divider (
  input wire logic i_clock,
  input wire logic i_reset,
  lbt_leak_if.divider leak
);

  logic [1:0] secondary_strobe_counter;
  logic [1:0] terminal;

  // limit 00 means four strobes: limit minus one wraps to 3
  assign terminal = 2'(leak.secondary_strobe_limit - 2'h1);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      secondary_strobe_counter <= 2'h0;
      leak.leak_pulse <= 1'b0;
    end else begin
      leak.leak_pulse <= 1'b0;
      if (leak.primary_strobe) begin
        if (secondary_strobe_counter == terminal) begin
          secondary_strobe_counter <= 2'h0;
          leak.leak_pulse <= 1'b1;
        end else begin
          secondary_strobe_counter <= 2'(secondary_strobe_counter + 2'h1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_last_strobe;
    leak.primary_strobe && secondary_strobe_counter == terminal;
  endsequence

  pulse_ratio_a: assert property (@(posedge i_clock) disable iff (i_reset)
    s_last_strobe |=> leak.leak_pulse)
    else $error("leak pulse missing after last strobe");

  pulse_cause_a: assert property (@(posedge i_clock) disable iff (i_reset)
    leak.leak_pulse |-> $past(leak.primary_strobe) && $past(secondary_strobe_counter) == $past(terminal))
    else $error("leak pulse without terminal strobe");

  counter_wrap_a: assert property (@(posedge i_clock) disable iff (i_reset)
    leak.leak_pulse |-> secondary_strobe_counter == 2'h0)
    else $error("secondary counter not cleared after pulse");

endmodule : lbt_secondary_divider
`default_nettype wire

//--- testbench/lbt_ce_counter_model.sv
// correctable-error counter model standing beside the leak timer
// assumes decrement pulses arrive on the same memory clock
`timescale 1ns/1ns
`default_nettype none
module lbt_ce_counter_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [7:0] i_load_value,
  input wire logic i_decrement,
  output logic [7:0] o_count,
  output logic o_zero
);
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_count <= 8'h00;
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (i_decrement && o_count != 8'h00) begin
      o_count <= o_count - 8'h01;
    end
  end
  assign o_zero = (o_count == 8'h00);
endmodule : lbt_ce_counter_model
`default_nettype wire

//--- testbench/tb_lbt_leak_timer.sv
// self-checking bench for the leak timer and its divider
// assumes one 100 MHz memory clock and synchronous reset
`timescale 1ns/1ns
`default_nettype none
module tb_lbt_leak_timer;
  logic clock, reset, cfg_write, cfg_read, ce_zero, strobe, ce_dec, ce_load;
  logic [7:0] cfg_addr, ce_load_value, ce_count;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [1:0] limit;
  int n_mismatch, total_checks, n;

  lbt_leak_timer i_dut (.i_clock(clock), .i_reset(reset), .i_cfg_write(cfg_write), .i_cfg_read(cfg_read),
    .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata), .i_secondary_strobe_limit(limit),
    .i_ce_counter_zero(ce_zero), .o_cfg_rdata(cfg_rdata), .o_primary_strobe(strobe), .o_ce_decrement(ce_dec));
  lbt_ce_counter_model i_ce (.i_clock(clock), .i_reset(reset), .i_load(ce_load), .i_load_value(ce_load_value),
    .i_decrement(ce_dec), .o_count(ce_count), .o_zero(ce_zero));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // bus cycles, waits and comparison
  // ---------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask : cfg_rd

  task automatic ce_preset(input logic [7:0] v);
    @(posedge clock);
    ce_load <= 1'b1;
    ce_load_value <= v;
    @(posedge clock);
    ce_load <= 1'b0;
  endtask : ce_preset

  // waits for a strobe; cnt is the number of cycles waited
  task automatic wait_strobe(input int max, input bit may_miss, output int cnt);
    cnt = 0;
    tick();
    cnt++;
    while (strobe !== 1'b1 && cnt < max) begin
      tick();
      cnt++;
    end
    if (strobe !== 1'b1 && !may_miss) begin
      chk(32'h0, 32'h1, "no strobe in time");
      give_verdict();
    end
  endtask : wait_strobe

  // counts strobes until a decrement, which must last one cycle
  task automatic wait_dec(input int max, output int strobes);
    int c;
    c = 0;
    strobes = 0;
    tick();
    while (ce_dec !== 1'b1 && c < max) begin
      if (strobe === 1'b1) strobes++;
      tick();
      c++;
    end
    if (ce_dec !== 1'b1) begin
      chk(32'h0, 32'h1, "no decrement in time");
      give_verdict();
    end
    tick();
    chk({31'h0, ce_dec}, 32'h0, "decrement too long");
  endtask : wait_dec

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic scen_reset_values;
    cfg_rd(8'hB8, rd);
    chk(rd, 32'h0, "config after reset");
    cfg_rd(8'hC0, rd);
    chk(rd, 32'h0, "low word after reset");
    cfg_rd(8'hC4, rd);
    chk(rd, 32'h0, "high word after reset");
    cfg_rd(8'hC8, rd);
    chk(rd, 32'h0, "unmapped read");
  endtask : scen_reset_values

  task automatic scen_no_leak;
    wait_strobe(4200, 1'b1, n);
    chk({31'h0, strobe}, 32'h0, "strobe with zero config");
    cfg_wr(8'hB8, 32'h0000_0A81);
    wait_strobe(4200, 1'b1, n);
    chk({31'h0, strobe}, 32'h0, "strobe with reserved code");
  endtask : scen_no_leak

  task automatic scen_timer_words;
    cfg_wr(8'hB8, 32'hFFFF_FFFF);
    cfg_rd(8'hB8, rd);
    chk(rd, 32'h0000_0FFF, "config readback");
    cfg_wr(8'hB8, 32'h0);
    cfg_wr(8'hC4, 32'hFFFF_FC00);
    cfg_rd(8'hC4, rd);
    chk(rd, 32'h0, "high word spare bits");
    cfg_wr(8'hC0, 32'hFFFF_FFFF);
    n = 0;
    rd = 32'h0;
    while (rd !== 32'h1 && n < 1100) begin
      cfg_rd(8'hC4, rd);
      n++;
    end
    chk(rd, 32'h1, "carry into high word");
    if (rd !== 32'h1) give_verdict();
    cfg_rd(8'hC0, rd);
    chk(rd, 32'h0, "low word wrap");
    repeat (1020) tick();
    cfg_rd(8'hC0, rd);
    chk(rd, 32'h0, "low word early step");
    repeat (1030) tick();
    cfg_rd(8'hC0, rd);
    chk(rd, 32'h1, "low word one step");
  endtask : scen_timer_words

  task automatic scen_period(input logic [5:0] hi, input logic [5:0] lo, input int period);
    cfg_wr(8'hB8, {20'h0, hi, lo});
    wait_strobe(2 * period + 10, 1'b0, n);
    tick();
    chk({31'h0, strobe}, 32'h0, "strobe too long");
    wait_strobe(2 * period, 1'b0, n);
    chk(32'(n + 1), 32'(period), "strobe period");
    cfg_rd(8'hC0, rd);
    chk(rd, 32'h0, "timer after match");
  endtask : scen_period

  task automatic scen_divider;
    logic [1:0] lims [4];
    int exps [4];
    lims = '{2'b10, 2'b11, 2'b00, 2'b01};
    exps = '{2, 3, 4, 1};
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    cfg_rd(8'hB8, rd);
    chk(rd, 32'h0, "config after second reset");
    cfg_rd(8'hC0, rd);
    chk(rd, 32'h0, "low word after second reset");
    cfg_wr(8'hB8, 32'h0000_0041);
    ce_preset(8'h14);
    @(posedge clock);
    limit <= 2'b01;
    wait_dec(4300, n);
    chk(32'(n), 32'h1, "strobes before first decrement");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      limit <= lims[i];
      wait_dec(17000, n);
      chk(32'(n), 32'(exps[i]), "strobes per decrement");
    end
    chk({24'h0, ce_count}, 32'h0000_000F, "error count");
    ce_preset(8'h00);
    wait_strobe(5000, 1'b0, n);
    repeat (4) begin
      tick();
      chk({31'h0, ce_dec}, 32'h0, "decrement at zero");
    end
    chk({24'h0, ce_count}, 32'h0, "count stays zero");
  endtask : scen_divider

  initial begin
    reset = 1'b1;
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
    limit = 2'b00;
    ce_load = 1'b0;
    ce_load_value = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    scen_reset_values();
    scen_no_leak();
    scen_timer_words();
    scen_period(6'h01, 6'h01, 4097);
    scen_period(6'h01, 6'h02, 12289);
    scen_divider();
    give_verdict();
  end
endmodule : tb_lbt_leak_timer
`default_nettype wire
